/* File: design/hbrs_sequencer.v */
// holding-brake release sequencer with regen resistor gate and axi4-lite registers
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "hbrs_defines.vh"
module hbrs_sequencer (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // drive inputs
  input wire servo_enable_i,
  input wire signed [15:0] motor_speed_i,
  input wire fault_class1_i,
  input wire fault_class2_i,
  input wire bus_at_brake_level_i,
  // outputs
  output reg brake_release_output_o,
  output reg motor_energize_o,
  output reg zero_speed_stop_o,
  output reg res_internal_en_o,
  output reg res_external_en_o,
  output reg irq_o
);
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_ROT_WAIT = 3'h2;
  localparam [2:0] ST_F2_DECEL = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_FAULT = 3'h5;

  function [31:0] hbrs_lane;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        hbrs_lane[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // clamp out-of-range writes instead of letting upper bits wrap
  function [9:0] hbrs_ms_clip;
    input [31:0] v;
    begin
      if (v < {22'h0, `HBRS_MS_MIN})
        hbrs_ms_clip = `HBRS_MS_MIN;
      else if (v > {22'h0, `HBRS_MS_MAX})
        hbrs_ms_clip = `HBRS_MS_MAX;
      else
        hbrs_ms_clip = v[9:0];
    end
  endfunction

  function [11:0] hbrs_rpm_clip;
    input [31:0] v;
    begin
      if (v > {20'h0, `HBRS_THRESH_MAX})
        hbrs_rpm_clip = `HBRS_THRESH_MAX;
      else
        hbrs_rpm_clip = v[11:0];
    end
  endfunction

  // read-back word of the writable registers
  function [31:0] hbrs_cfg_word;
    input [7:0] a;
    input [1:0] c;
    input [11:0] th;
    input [9:0] tmo;
    input [9:0] dly;
    input [`HBRS_IRQ_W-1:0] en;
    begin
      case (a)
        `HBRS_ADDR_CTRL: hbrs_cfg_word = {30'h0, c};
        `HBRS_ADDR_THRESH: hbrs_cfg_word = {20'h0, th};
        `HBRS_ADDR_TIMEOUT: hbrs_cfg_word = {22'h0, tmo};
        `HBRS_ADDR_DEENERGIZE: hbrs_cfg_word = {22'h0, dly};
        `HBRS_ADDR_IRQ_EN: hbrs_cfg_word = {28'h0, en};
        default: hbrs_cfg_word = 32'h0;
      endcase
    end
  endfunction

  // configuration and interrupt status
  reg [1:0] ctrl;
  reg [11:0] release_speed_threshold;
  reg [9:0] rotating_release_timeout;
  reg [9:0] static_deenergize_delay;
  reg [`HBRS_IRQ_W-1:0] irq_stat;
  reg [`HBRS_IRQ_W-1:0] irq_en;

  reg [2:0] state;
  reg [2:0] next_state;
  reg have_aw;
  reg have_w;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg tmr_load;
  reg [9:0] tmr_ms;
  reg regen_prev;
  wire tmr_done;
  wire [15:0] speed_abs;
  wire static_motor;
  wire at_threshold;
  wire brake_used;
  wire wr_fire;
  wire [31:0] cur_word;
  wire [31:0] new_word;
  wire [`HBRS_IRQ_W-1:0] irq_evt;
  wire [`HBRS_IRQ_W-1:0] irq_clr;
  wire brake_off_evt;
  wire deenergize_evt;

  assign speed_abs = motor_speed_i[15] ? (~motor_speed_i + 16'h1) : motor_speed_i;
  assign static_motor = speed_abs < {4'h0, `HBRS_STATIC_RPM};
  assign at_threshold = speed_abs <= {4'h0, release_speed_threshold};
  assign brake_used = ctrl[`HBRS_CTRL_BK_ASSIGNED];

  hbrs_ms_timer hbrs_ms_timer_i (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .ms_i(tmr_ms),
    .done_o(tmr_done)
  );

  // sequencer
  always @* begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_ms = static_deenergize_delay;
    case (state)
      ST_OFF: begin
        if (servo_enable_i && !fault_class1_i && !fault_class2_i)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (fault_class2_i) begin
          next_state = ST_F2_DECEL;
        end else if (!servo_enable_i || fault_class1_i) begin
          if (!brake_used) begin
            next_state = ST_OFF;
          end else if (static_motor) begin
            next_state = ST_HOLD;
            tmr_load = 1'b1;
          end else begin
            next_state = ST_ROT_WAIT;
            tmr_load = 1'b1;
            tmr_ms = rotating_release_timeout;
          end
        end
      end
      ST_ROT_WAIT: begin
        if (fault_class2_i) begin
          next_state = ST_F2_DECEL;
        end else if (at_threshold || tmr_done) begin
          next_state = ST_HOLD;
          tmr_load = 1'b1;
          tmr_ms = `HBRS_ROT_HOLD_MS;
        end
      end
      ST_F2_DECEL: begin
        if (!brake_used) begin
          next_state = ST_FAULT;
        end else if (static_motor) begin
          next_state = ST_HOLD;
          tmr_load = 1'b1;
        end
      end
      ST_HOLD: begin
        if (tmr_done)
          next_state = fault_class2_i ? ST_FAULT : ST_OFF;
      end
      ST_FAULT: begin
        if (!fault_class2_i)
          next_state = ST_OFF;
      end
      default: next_state = ST_OFF;
    endcase
  end

  assign brake_off_evt = brake_release_output_o && (next_state == ST_HOLD || next_state == ST_OFF
                         || next_state == ST_FAULT);
  assign deenergize_evt = (state == ST_HOLD) && tmr_done;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
      brake_release_output_o <= 1'b0;
      motor_energize_o <= 1'b0;
      zero_speed_stop_o <= 1'b0;
      res_internal_en_o <= 1'b0;
      res_external_en_o <= 1'b0;
      regen_prev <= 1'b0;
    end else begin
      state <= next_state;
      brake_release_output_o <= brake_used && (next_state == ST_RUN || next_state == ST_ROT_WAIT
                                || next_state == ST_F2_DECEL);
      motor_energize_o <= (next_state != ST_OFF) && (next_state != ST_FAULT);
      zero_speed_stop_o <= next_state == ST_ROT_WAIT || next_state == ST_F2_DECEL;
      regen_prev <= bus_at_brake_level_i;
      res_internal_en_o <= bus_at_brake_level_i && !ctrl[`HBRS_CTRL_RES_EXTERNAL];
      res_external_en_o <= bus_at_brake_level_i && ctrl[`HBRS_CTRL_RES_EXTERNAL];
    end
  end

  // interrupt status: set wins over clear
  assign irq_evt[`HBRS_IRQ_BRAKE_OFF] = brake_off_evt;
  assign irq_evt[`HBRS_IRQ_DEENERGIZED] = deenergize_evt;
  assign irq_evt[`HBRS_IRQ_FAULT2] = fault_class2_i && state != ST_F2_DECEL && next_state == ST_F2_DECEL;
  assign irq_evt[`HBRS_IRQ_REGEN] = bus_at_brake_level_i && !regen_prev;
  assign irq_clr = (wr_fire && aw_addr == `HBRS_ADDR_IRQ_CLR) ? w_data[`HBRS_IRQ_W-1:0] : {`HBRS_IRQ_W{1'b0}};

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat <= {`HBRS_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      irq_o <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
    end
  end

  // axi4-lite write path
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;
  assign cur_word = hbrs_cfg_word(aw_addr, ctrl, release_speed_threshold, rotating_release_timeout,
                                  static_deenergize_delay, irq_en);
  assign new_word = hbrs_lane(cur_word, w_data, w_strb);

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `HBRS_CTRL_RESET;
      release_speed_threshold <= `HBRS_THRESH_RESET;
      rotating_release_timeout <= `HBRS_TIMEOUT_RESET;
      static_deenergize_delay <= `HBRS_DEENERGIZE_RESET;
      irq_en <= {`HBRS_IRQ_W{1'b0}};
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `HBRS_ADDR_CTRL: ctrl <= new_word[1:0];
          `HBRS_ADDR_THRESH: release_speed_threshold <= hbrs_rpm_clip(new_word);
          `HBRS_ADDR_TIMEOUT: rotating_release_timeout <= hbrs_ms_clip(new_word);
          `HBRS_ADDR_DEENERGIZE: static_deenergize_delay <= hbrs_ms_clip(new_word);
          `HBRS_ADDR_IRQ_EN: irq_en <= new_word[`HBRS_IRQ_W-1:0];
          `HBRS_ADDR_IRQ_CLR: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[7:2], 2'b00})
          `HBRS_ADDR_CTRL, `HBRS_ADDR_THRESH, `HBRS_ADDR_TIMEOUT, `HBRS_ADDR_DEENERGIZE, `HBRS_ADDR_IRQ_EN:
            s_axi_rdata <= hbrs_cfg_word({s_axi_araddr[7:2], 2'b00}, ctrl, release_speed_threshold,
                                         rotating_release_timeout, static_deenergize_delay, irq_en);
          `HBRS_ADDR_STATUS: s_axi_rdata <= {24'h0, 1'b0, state, res_external_en_o, res_internal_en_o,
                                             motor_energize_o, brake_release_output_o};
          `HBRS_ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
          `HBRS_ADDR_IRQ_CLR: s_axi_rdata <= 32'h0;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // hbrs_sequencer

/* File: common/hbrs_defines.vh */
// register map, field positions, reset values and timing counts of the brake sequencer
`ifndef HBRS_DEFINES_VH
`define HBRS_DEFINES_VH
`define HBRS_CLK_MHZ 250
`define HBRS_MS_LAST 18'h3d08f
`define HBRS_ADDR_CTRL 8'h00
`define HBRS_ADDR_THRESH 8'h04
`define HBRS_ADDR_TIMEOUT 8'h08
`define HBRS_ADDR_DEENERGIZE 8'h0c
`define HBRS_ADDR_STATUS 8'h10
`define HBRS_ADDR_IRQ_STAT 8'h14
`define HBRS_ADDR_IRQ_EN 8'h18
`define HBRS_ADDR_IRQ_CLR 8'h1c
`define HBRS_CTRL_BK_ASSIGNED 0
`define HBRS_CTRL_RES_EXTERNAL 1
`define HBRS_CTRL_RESET 2'h1
`define HBRS_THRESH_RESET 12'h01e
`define HBRS_THRESH_MAX 12'hbb8
`define HBRS_TIMEOUT_RESET 10'h1f4
`define HBRS_DEENERGIZE_RESET 10'h096
`define HBRS_MS_MIN 10'h001
`define HBRS_MS_MAX 10'h3e8
`define HBRS_STATIC_RPM 12'h014
`define HBRS_ROT_HOLD_MS 10'h032
`define HBRS_IRQ_BRAKE_OFF 0
`define HBRS_IRQ_DEENERGIZED 1
`define HBRS_IRQ_FAULT2 2
`define HBRS_IRQ_REGEN 3
`define HBRS_IRQ_W 4
`endif

/* File: design/hbrs_ms_timer.v */
// millisecond tick and down-counting delay timer
`timescale 1ns/1ps
`include "hbrs_defines.vh"
module hbrs_ms_timer (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // control
  input wire load_i,
  input wire [9:0] ms_i,
  // status
  output reg done_o
);
  localparam [17:0] MS_LAST = `HBRS_MS_LAST;
  reg [17:0] prescale;
  reg [9:0] remain;
  reg running;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      prescale <= 18'h0;
      remain <= 10'h0;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      prescale <= 18'h0;
      remain <= ms_i;
      running <= 1'b1;
      done_o <= 1'b0;
    end else if (running) begin
      if (prescale == MS_LAST) begin
        prescale <= 18'h0;
        if (remain <= 10'h1) begin
          running <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remain <= remain - 10'h1;
        end
      end else begin
        prescale <= prescale + 18'h1;
      end
    end
  end
endmodule // hbrs_ms_timer

/* File: verification/hbrs_seq_props_properties.sv */
// assertion checker for the brake sequencer ports
`timescale 1ns/1ps
module hbrs_seq_props (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // register writes
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  // drive side
  input wire servo_enable_i,
  input wire signed [15:0] motor_speed_i,
  input wire fault_class2_i,
  input wire bus_at_brake_level_i,
  input wire brake_release_output_o,
  input wire motor_energize_o,
  input wire zero_speed_stop_o,
  input wire res_internal_en_o,
  input wire res_external_en_o
);
  logic bk_used;
  wire [15:0] mag = motor_speed_i[15] ? -motor_speed_i : motor_speed_i;
  wire brk = brake_release_output_o;
  wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // mirror of the brake-assigned control bit
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      bk_used <= 1'b1;
    end else if (aw_w && s_axi_awaddr == 8'h00 && s_axi_wstrb[0]) begin
      bk_used <= s_axi_wdata[0];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence enable_drop;
    $fell(servo_enable_i) && bk_used && brk;
  endsequence
  sequence class2_run;
    fault_class2_i && $past(fault_class2_i) && bk_used && brk;
  endsequence
  chk_static_off: assert property ((enable_drop ##0 mag < 16'h0014) |=> !brk)
    else $error("brake held after static disable");
  chk_class2_hold: assert property ((class2_run ##0 mag >= 16'h0014) |=> brk)
    else $error("brake applied before speed fell");
  chk_class2_off: assert property ((class2_run ##0 mag < 16'h0014) |=> !brk)
    else $error("brake not applied below static speed");
  chk_class2_decel: assert property ($rose(fault_class2_i) && brk && bk_used |=> zero_speed_stop_o)
    else $error("no zero speed stop on class two fault");
  chk_hold_energy: assert property ($fell(brk) && motor_energize_o |=> motor_energize_o [*7])
    else $error("drive dropped too soon after brake");
  chk_brake_energy: assert property (brk |-> motor_energize_o)
    else $error("brake released without drive");
  chk_no_brake_fn: assert property (!bk_used && $fell(servo_enable_i) && motor_energize_o && !zero_speed_stop_o
                                    && !fault_class2_i |=> !brk && !motor_energize_o)
    else $error("delays used without brake function");
  chk_regen_on: assert property (bus_at_brake_level_i |=> res_internal_en_o || res_external_en_o)
    else $error("resistor not enabled at braking level");
  chk_regen_off: assert property (!bus_at_brake_level_i |=> !res_internal_en_o && !res_external_en_o)
    else $error("resistor enabled below braking level");
  chk_res_single: assert property (!(res_internal_en_o && res_external_en_o))
    else $error("both resistors enabled");
  chk_write_resp: assert property (aw_w |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
endmodule // hbrs_seq_props
bind hbrs_sequencer hbrs_seq_props hbrs_seq_props_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .servo_enable_i(servo_enable_i),
  .motor_speed_i(motor_speed_i), .fault_class2_i(fault_class2_i), .bus_at_brake_level_i(bus_at_brake_level_i),
  .brake_release_output_o(brake_release_output_o), .motor_energize_o(motor_energize_o),
  .zero_speed_stop_o(zero_speed_stop_o), .res_internal_en_o(res_internal_en_o),
  .res_external_en_o(res_external_en_o));

/* File: verification/hbrs_load_model.sv */
// motor and dc bus model at the far side of the sequencer
`timescale 1ns/1ps
module hbrs_load_model (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // bench control
  input wire load_i,
  input wire signed [15:0] speed_set_i,
  input wire regen_i,
  // from the sequencer
  input wire zero_speed_stop_i,
  // to the sequencer
  output logic signed [15:0] speed_o,
  output logic bus_high_o
);
  // motor slows one rpm a cycle while the drive stops it
  always @(posedge sys_clk_i) begin
    bus_high_o <= regen_i && !rst_i;
    if (rst_i) begin
      speed_o <= 16'sh0000;
    end else if (load_i) begin
      speed_o <= speed_set_i;
    end else if (zero_speed_stop_i && speed_o != 16'sh0000) begin
      speed_o <= speed_o[15] ? speed_o + 16'sh0001 : speed_o - 16'sh0001;
    end
  end
endmodule // hbrs_load_model

/* File: verification/hbrs_sequencer_tb.sv */
// self-checking bench for the brake sequencer
`timescale 1ns/1ps
`include "hbrs_defines.vh"
module hbrs_sequencer_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic servo_enable_i = 1'b0, fault_class1_i = 1'b0, fault_class2_i = 1'b0, ld = 1'b0, regen = 1'b0;
  logic signed [15:0] spd = 16'sh0000;
  logic signed [15:0] motor_speed_i;
  logic bus_at_brake_level_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic brake_release_output_o, motor_energize_o, zero_speed_stop_o, res_internal_en_o, res_external_en_o, irq_o;
  integer bad_count = 0;
  integer compares = 0;
  wire [15:0] mag = motor_speed_i[15] ? -motor_speed_i : motor_speed_i;
  always #2 sys_clk_i = ~sys_clk_i;
  hbrs_sequencer hbrs_sequencer_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .servo_enable_i(servo_enable_i), .motor_speed_i(motor_speed_i),
    .fault_class1_i(fault_class1_i), .fault_class2_i(fault_class2_i), .bus_at_brake_level_i(bus_at_brake_level_i),
    .brake_release_output_o(brake_release_output_o), .motor_energize_o(motor_energize_o),
    .zero_speed_stop_o(zero_speed_stop_o), .res_internal_en_o(res_internal_en_o),
    .res_external_en_o(res_external_en_o), .irq_o(irq_o));
  hbrs_load_model hbrs_load_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(ld), .speed_set_i(spd),
    .regen_i(regen), .zero_speed_stop_i(zero_speed_stop_o), .speed_o(motor_speed_i), .bus_high_o(bus_at_brake_level_i));
  task chk(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0t saw %h want %h", $time, s, e);
      end
    end
  endtask
  task wrap_up;
    begin
      if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task lim(input integer n);
    begin
      if (n >= 400) begin
        bad_count = bad_count + 1;
        $display("BAD %0t timeout", $time);
        wrap_up;
      end
    end
  endtask
  task cy(input integer k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      @(posedge sys_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk_i);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 400);
      s_axi_bready <= 1'b0;
      lim(n);
      chk(s_axi_bresp, r);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] r);
    integer n;
    begin
      @(posedge sys_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk_i);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 400);
      s_axi_rready <= 1'b0;
      lim(n);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
    end
  endtask
  task wb(input v);
    integer n;
    begin
      n = 0;
      while (brake_release_output_o !== v && n < 400) begin
        @(posedge sys_clk_i);
        n = n + 1;
      end
      lim(n);
    end
  endtask
  task rs;
    begin
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      servo_enable_i <= 1'b0;
      fault_class1_i <= 1'b0;
      fault_class2_i <= 1'b0;
      regen <= 1'b0;
      cy(16);
      rst_i <= 1'b0;
    end
  endtask
  task run(input [15:0] v, input b);
    integer n;
    begin
      @(posedge sys_clk_i);
      ld <= 1'b1;
      spd <= v;
      servo_enable_i <= 1'b1;
      @(posedge sys_clk_i);
      ld <= 1'b0;
      n = 0;
      while (motor_energize_o !== 1'b1 && n < 400) begin
        @(posedge sys_clk_i);
        n = n + 1;
      end
      lim(n);
      chk(brake_release_output_o, b);
    end
  endtask
  task t_regs;
    begin
      rd(`HBRS_ADDR_CTRL, 32'h1, 2'b00);
      rd(`HBRS_ADDR_THRESH, 32'h1e, 2'b00);
      rd(`HBRS_ADDR_TIMEOUT, 32'h1f4, 2'b00);
      rd(`HBRS_ADDR_DEENERGIZE, 32'h96, 2'b00);
      rd(8'h20, 32'h0, 2'b10);
      wr(`HBRS_ADDR_THRESH, 32'h1000, 2'b00);
      rd(`HBRS_ADDR_THRESH, 32'hbb8, 2'b00);
      wr(`HBRS_ADDR_TIMEOUT, 32'h0, 2'b00);
      rd(`HBRS_ADDR_TIMEOUT, 32'h1, 2'b00);
      wr(`HBRS_ADDR_DEENERGIZE, 32'h7d0, 2'b00);
      rd(`HBRS_ADDR_DEENERGIZE, 32'h3e8, 2'b00);
      wr(`HBRS_ADDR_STATUS, 32'h0, 2'b10);
    end
  endtask
  task t_static;
    begin
      rs;
      run(16'h0013, 1'b1);
      servo_enable_i <= 1'b0;
      cy(3);
      chk(brake_release_output_o, 1'b0);
      cy(50);
      chk(motor_energize_o, 1'b1);
    end
  endtask
  task t_rot(input [7:0] th, input f1);
    begin
      rs;
      wr(`HBRS_ADDR_THRESH, {24'h0, th}, 2'b00);
      run(f1 ? 16'h0064 : 16'hff9c, 1'b1);
      if (f1) fault_class1_i <= 1'b1;
      else servo_enable_i <= 1'b0;
      wb(1'b0);
      chk(mag <= th && mag >= th - 4, 1'b1);
      chk(motor_energize_o, 1'b1);
    end
  endtask
  task t_f2;
    begin
      rs;
      wr(`HBRS_ADDR_THRESH, 32'hbb8, 2'b00);
      wr(`HBRS_ADDR_IRQ_EN, 32'h4, 2'b00);
      run(16'h0064, 1'b1);
      fault_class2_i <= 1'b1;
      cy(4);
      chk({zero_speed_stop_o, brake_release_output_o, irq_o}, 3'h7);
      wb(1'b0);
      chk(mag < 20 && mag >= 16, 1'b1);
      chk(motor_energize_o, 1'b1);
      rd(`HBRS_ADDR_IRQ_STAT, 32'h5, 2'b00);
      wr(`HBRS_ADDR_IRQ_CLR, 32'h4, 2'b00);
      rd(`HBRS_ADDR_IRQ_STAT, 32'h1, 2'b00);
      chk(irq_o, 1'b0);
    end
  endtask
  task t_nobk;
    begin
      rs;
      wr(`HBRS_ADDR_CTRL, 32'h0, 2'b00);
      run(16'h0064, 1'b0);
      servo_enable_i <= 1'b0;
      cy(3);
      chk({brake_release_output_o, motor_energize_o}, 2'h0);
    end
  endtask
  task t_regen(input [31:0] c, input [1:0] e);
    begin
      rs;
      wr(`HBRS_ADDR_CTRL, c, 2'b00);
      wr(`HBRS_ADDR_IRQ_EN, 32'h8, 2'b00);
      regen <= 1'b1;
      cy(4);
      chk({res_external_en_o, res_internal_en_o, irq_o}, {e, 1'b1});
      regen <= 1'b0;
      cy(4);
      chk({res_external_en_o, res_internal_en_o}, 2'h0);
    end
  endtask
  initial begin
    rs;
    t_regs;
    t_static;
    t_rot(8'd30, 1'b0);
    t_rot(8'd50, 1'b1);
    t_f2;
    t_nobk;
    t_regen(32'h1, 2'h1);
    t_regen(32'h3, 2'h2);
    wrap_up;
  end
endmodule // hbrs_sequencer_tb
